// ===== utx_pkg.sv
// Package with register map, field positions and reset values of the transmitter.
package utx_pkg;
  localparam logic [7:0]  ADDR_STATUS_A  = 8'h00;
  localparam logic [7:0]  ADDR_CONTROL_B = 8'h04;
  localparam logic [7:0]  ADDR_CONTROL_C = 8'h08;
  localparam logic [7:0]  ADDR_BAUD      = 8'h0C;
  localparam logic [7:0]  ADDR_DATA      = 8'h10;
  localparam int          STA_TXC        = 6;
  localparam int          STA_UDRE       = 5;
  localparam int          STA_DS         = 1;
  localparam int          CTB_TXCIE      = 6;
  localparam int          CTB_UDRIE      = 5;
  localparam int          CTB_TX_EN      = 3;
  localparam int          CTB_SIZE2      = 2;
  localparam int          CTB_NINTH      = 0;
  localparam int          CTC_SYNC       = 6;
  localparam int          CTC_PAR_HI     = 5;
  localparam int          CTC_PAR_LO     = 4;
  localparam int          CTC_STOP2      = 3;
  localparam int          CTC_SIZE1      = 2;
  localparam int          CTC_SIZE0      = 1;
  localparam int          CTC_POL        = 0;
  localparam logic [7:0]  CTB_RESET      = 8'h00;
  localparam logic [7:0]  CTC_RESET      = 8'h06;
  localparam logic [11:0] BAUD_RESET     = 12'h000;
  localparam int          FRAME_W        = 13;
  localparam logic [3:0]  OVS_NORMAL     = 4'hF;
  localparam logic [3:0]  OVS_DOUBLE     = 4'h7;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
endpackage : utx_pkg

// ===== utx_frame_if.sv
// Interface between the transmit control logic and the frame shifter.
`timescale 1ns/10ps
interface utx_frame_if;
  logic                        load;
  logic [utx_pkg::FRAME_W-1:0] frame;
  logic [3:0]                  nbits;
  logic                        tick;
  logic                        busy;
  logic                        done;
  logic                        line;
  modport ctl (output load, frame, nbits, tick, input busy, done, line);
  modport shf (input load, frame, nbits, tick, output busy, done, line);
endinterface : utx_frame_if

// ===== utx_baud_gen.sv
// Baud down-counter and bit-period prescaler that paces the frame shifter.
`timescale 1ns/10ps
module utx_baud_gen #(
  parameter int DIV_W = 12
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [DIV_W-1:0] divisor,
  input  wire logic             reload,
  input  wire logic             double_speed,
  input  wire logic             sync_mode,
  input  wire logic             ext_edge,
  input  wire logic             run,
  output logic                  bit_tick
);
  logic [DIV_W-1:0] count;
  logic [3:0]       phase;
  logic             baud_clk;
  logic [3:0]       top;

  if (DIV_W < 1 || DIV_W > 16) begin : g_chk
    $error("DIV_W must lie between 1 and 16.");
  end

  assign baud_clk = (count == '0) && !reload;
  assign top      = double_speed ? utx_pkg::OVS_DOUBLE : utx_pkg::OVS_NORMAL;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count <= '0;
    end else if (reload || count == '0) begin
      count <= divisor;
    end else begin
      count <= count - 1'b1;
    end
  end

  // The prescaler is held at zero while idle so that a start bit lasts a full period.
  // It restarts after each bit so that double speed gives eight baud clocks to every bit.
  always_ff @(posedge ref_clk) begin
    if (reset || !run) begin
      phase <= 4'h0;
    end else if (baud_clk) begin
      phase <= (phase == top) ? 4'h0 : phase + 4'h1;
    end
  end

  always_comb begin
    if (sync_mode) begin
      bit_tick = ext_edge;
    end else begin
      bit_tick = baud_clk && (phase == top);
    end
  end
endmodule : utx_baud_gen

// ===== utx_shifter.sv
// Transmit shift register that sends one prepared frame, least significant bit first.
`timescale 1ns/10ps
module utx_shifter (
  input  wire logic ref_clk,
  input  wire logic reset,
  utx_frame_if.shf  f
);
  logic [utx_pkg::FRAME_W-1:0] shreg;
  logic [3:0]                  remain;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shreg  <= '1;
      remain <= 4'h0;
      f.busy <= 1'b0;
      f.done <= 1'b0;
    end else begin
      f.done <= 1'b0;
      if (f.load) begin
        shreg  <= f.frame;
        remain <= f.nbits;
        f.busy <= 1'b1;
      end else if (f.busy && f.tick) begin
        shreg <= {1'b1, shreg[utx_pkg::FRAME_W-1:1]};
        if (remain == 4'h1) begin
          f.busy <= 1'b0;
          f.done <= 1'b1;
        end else begin
          remain <= remain - 4'h1;
        end
      end
    end
  end

  assign f.line = f.busy ? shreg[0] : 1'b1;
endmodule : utx_shifter

// ===== utx_top.sv
// Serial transmitter with parity, ninth bit, status flags and AHB-Lite registers.
//
// Overview of operation
// - Parity is the XOR of all data bits, inverted for odd parity.
// - When parity is enabled, the parity bit follows the last data bit.
// - While transmit enable is set, the transmitter drives the serial output pin.
// - In synchronous mode the external clock pin paces transmission.
// - Writing the data register loads the transmit buffer; sending starts only while the transmitter is active.
// - Buffer moves to shift register when idle or right after the last stop bit.
// - Bit rate comes from baud divisor and double speed, or external clock.
// - Data bits above the configured character size are ignored.
// - Buffer-empty flag is set while the buffer holds no pending character.
// - Writing the data register clears the buffer-empty flag.
// - Buffer-empty interrupt requested while enabled and flag set, gated globally.
// - Transmit-complete flag sets when the frame is out and buffer empty.
// - Transmit-complete flag clears on interrupt service or writing one.
// - Transmit-complete interrupt raised while enabled and flag set, gated globally.
// - Clearing transmit enable waits until shifter and buffer are empty.
// - After the disable takes effect the serial pin returns to the port.
// - Frame is start bit, data LSB first, parity, stop bits; idle high.
// - Five to nine data bits, none, even or odd parity, one or two stops.
// - Baud down-counter reloads from divisor; transmitter divides by 8 or 16.
`timescale 1ns/10ps
module utx_top #(
  parameter int DIV_W = 12
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        sync_clock_pin,
  input  wire logic        global_irq_enable,
  input  wire logic        tx_complete_irq_ack,
  output logic             serial_out_pin,
  output logic             serial_out_oe,
  output logic             irq_tx_buffer_empty,
  output logic             irq_tx_complete
);
  logic [7:0]       serial_control_b;
  logic [7:0]       serial_control_c;
  logic [DIV_W-1:0] baud_divisor_register;
  logic             double_speed_bit;
  logic             tx_complete_flag;
  logic             buf_full;
  logic [8:0]       buf_data;
  logic             tx_active;
  logic             wr_pend;
  logic [7:0]       wr_addr;
  logic             wr_data;
  logic             wr_status;
  logic             wr_ctl_b;
  logic             wr_ctl_c;
  logic             wr_baud;
  logic             addr_ok;
  logic [31:0]      next_rdata;
  logic             xck_s1;
  logic             xck_s2;
  logic             xck_s3;
  logic             xck_edge;
  logic [3:0]       char_bits;
  logic [8:0]       masked;
  logic             parity;
  logic             parity_enable_bit;
  logic             tx_buffer_empty_flag;
  logic             tx_ninth_bit;
  logic             transmit_enable_bit;

  utx_frame_if fr ();

  if (DIV_W < 1 || DIV_W > 16) begin : g_chk
    $error("DIV_W must lie between 1 and 16.");
  end

  // Character size code to number of data bits; code 7 means nine bits.
  function automatic logic [3:0] utx_char_bits(input logic [2:0] code);
    case (code)
      3'h0:    utx_char_bits = 4'h5;
      3'h1:    utx_char_bits = 4'h6;
      3'h2:    utx_char_bits = 4'h7;
      3'h7:    utx_char_bits = 4'h9;
      default: utx_char_bits = 4'h8;
    endcase
  endfunction : utx_char_bits

  assign transmit_enable_bit  = serial_control_b[utx_pkg::CTB_TX_EN];
  assign tx_ninth_bit         = serial_control_b[utx_pkg::CTB_NINTH];
  assign parity_enable_bit    = serial_control_c[utx_pkg::CTC_PAR_HI];
  assign tx_buffer_empty_flag = !buf_full;

  // Bus access: address phase is sampled, writes complete in the data phase.
  assign addr_ok = hsel && hready && (htrans == utx_pkg::HTRANS_NONSEQ);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (hready) begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  assign wr_status = wr_pend && (wr_addr == utx_pkg::ADDR_STATUS_A);
  assign wr_ctl_b  = wr_pend && (wr_addr == utx_pkg::ADDR_CONTROL_B);
  assign wr_ctl_c  = wr_pend && (wr_addr == utx_pkg::ADDR_CONTROL_C);
  assign wr_baud   = wr_pend && (wr_addr == utx_pkg::ADDR_BAUD);
  assign wr_data   = wr_pend && (wr_addr == utx_pkg::ADDR_DATA);

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (haddr[7:0])
      utx_pkg::ADDR_STATUS_A: begin
        next_rdata[utx_pkg::STA_TXC]  = tx_complete_flag;
        next_rdata[utx_pkg::STA_UDRE] = tx_buffer_empty_flag;
        next_rdata[utx_pkg::STA_DS]   = double_speed_bit;
      end
      utx_pkg::ADDR_CONTROL_B: begin
        next_rdata[7:0] = serial_control_b;
      end
      utx_pkg::ADDR_CONTROL_C: begin
        next_rdata[7:0] = serial_control_c;
      end
      utx_pkg::ADDR_BAUD: begin
        next_rdata[DIV_W-1:0] = baud_divisor_register;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Configuration registers.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      serial_control_b <= utx_pkg::CTB_RESET;
    end else if (wr_ctl_b) begin
      serial_control_b <= hwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      serial_control_c <= utx_pkg::CTC_RESET;
    end else if (wr_ctl_c) begin
      serial_control_c <= hwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      baud_divisor_register <= DIV_W'(utx_pkg::BAUD_RESET);
    end else if (wr_baud) begin
      baud_divisor_register <= hwdata[DIV_W-1:0];
    end
  end

  // The buffer-empty position of a status write is ignored; only double speed is kept.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      double_speed_bit <= 1'b0;
    end else if (wr_status) begin
      double_speed_bit <= hwdata[utx_pkg::STA_DS];
    end
  end

  // Transmit buffer; a write in the cycle of a move still leaves the buffer full.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      buf_full <= 1'b0;
      buf_data <= 9'h000;
    end else if (wr_data) begin
      buf_full <= 1'b1;
      buf_data <= {tx_ninth_bit, hwdata[7:0]};
    end else if (fr.load) begin
      buf_full <= 1'b0;
    end
  end

  // The transmitter stays active after enable clears until all pending data is sent.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_active <= 1'b0;
    end else if (transmit_enable_bit) begin
      tx_active <= 1'b1;
    end else if (!fr.busy && !buf_full && !fr.load) begin
      tx_active <= 1'b0;
    end
  end

  // Frame assembly from the buffered character.
  always_comb begin
    char_bits = utx_char_bits({serial_control_b[utx_pkg::CTB_SIZE2],
                               serial_control_c[utx_pkg::CTC_SIZE1],
                               serial_control_c[utx_pkg::CTC_SIZE0]});
    masked = 9'h000;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(char_bits)) begin
        masked[i] = buf_data[i];
      end
    end
    parity = (^masked) ^ serial_control_c[utx_pkg::CTC_PAR_LO];
  end

  always_comb begin
    fr.frame    = '1;
    fr.frame[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(char_bits)) begin
        fr.frame[i+1] = masked[i];
      end
    end
    if (parity_enable_bit) begin
      fr.frame[char_bits+4'h1] = parity;
    end
    fr.nbits = 4'h2 + char_bits + {3'h0, parity_enable_bit}
             + {3'h0, serial_control_c[utx_pkg::CTC_STOP2]};
  end

  // Move the buffer when the shifter is idle, which includes the cycle in which done is high.
  assign fr.load = tx_active && buf_full && !fr.busy;

  // External clock pin synchroniser and edge select.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      xck_s1 <= 1'b0;
      xck_s2 <= 1'b0;
      xck_s3 <= 1'b0;
    end else begin
      xck_s1 <= sync_clock_pin;
      xck_s2 <= xck_s1;
      xck_s3 <= xck_s2;
    end
  end

  assign xck_edge = serial_control_c[utx_pkg::CTC_POL] ? (xck_s3 && !xck_s2) : (!xck_s3 && xck_s2);

  utx_baud_gen #(
    .DIV_W (DIV_W)
  ) u_baud (
    .ref_clk      (ref_clk),
    .reset        (reset),
    .divisor      (baud_divisor_register),
    .reload       (wr_baud),
    .double_speed (double_speed_bit),
    .sync_mode    (serial_control_c[utx_pkg::CTC_SYNC]),
    .ext_edge     (xck_edge),
    .run          (fr.busy),
    .bit_tick     (fr.tick)
  );

  utx_shifter u_shift (
    .ref_clk (ref_clk),
    .reset   (reset),
    .f       (fr)
  );

  // Transmit-complete flag: a completing frame wins over a clear in the same cycle.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_complete_flag <= 1'b0;
    end else if (fr.done && !buf_full) begin
      tx_complete_flag <= 1'b1;
    end else if (tx_complete_irq_ack || (wr_status && hwdata[utx_pkg::STA_TXC])) begin
      tx_complete_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_tx_buffer_empty <= 1'b0;
      irq_tx_complete     <= 1'b0;
    end else begin
      irq_tx_buffer_empty <= global_irq_enable && serial_control_b[utx_pkg::CTB_UDRIE]
                             && tx_buffer_empty_flag;
      irq_tx_complete     <= global_irq_enable && serial_control_b[utx_pkg::CTB_TXCIE]
                             && tx_complete_flag && !tx_complete_irq_ack;
    end
  end

  // Pin override follows the effective enable, not the register bit.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      serial_out_pin <= 1'b1;
      serial_out_oe  <= 1'b0;
    end else begin
      serial_out_pin <= tx_active ? fr.line : 1'b1;
      serial_out_oe  <= tx_active;
    end
  end
endmodule : utx_top

// ===== utx_assertions.sv
// Checker with concurrent assertions on the transmitter's top-level ports.
`timescale 1ns/10ps
module utx_assertions (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        global_irq_enable,
  input wire logic        tx_complete_irq_ack,
  input wire logic        serial_out_pin,
  input wire logic        serial_out_oe,
  input wire logic        irq_tx_buffer_empty,
  input wire logic        irq_tx_complete
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic cb_wr;
  logic en_seen;
  // Shadow of the transmit enable bit, taken from the data phase of control_b writes.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cb_wr   <= 1'b0;
      en_seen <= 1'b0;
    end else begin
      cb_wr <= hsel && hready && htrans == utx_pkg::HTRANS_NONSEQ && hwrite && haddr[7:0] == utx_pkg::ADDR_CONTROL_B;
      if (cb_wr) begin
        en_seen <= hwdata[utx_pkg::CTB_TX_EN];
      end
    end
  end
  sequence data_read_s;
    hsel && hready && htrans == utx_pkg::HTRANS_NONSEQ && !hwrite && haddr[7:0] == utx_pkg::ADDR_DATA;
  endsequence
  sequence bit_fall_s;
    $fell(serial_out_pin);
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  data_reads_zero_a: assert property (data_read_s |=> hrdata == 32'h0)
    else $error("data register read not zero");
  start_driven_a: assert property (bit_fall_s |-> serial_out_oe)
    else $error("line fell while not driven");
  bit_min_len_a: assert property (bit_fall_s |-> !serial_out_pin [*8])
    else $error("low bit shorter than eight cycles");
  idle_high_a: assert property (!serial_out_oe |-> serial_out_pin)
    else $error("released line not high");
  release_idle_a: assert property ($fell(serial_out_oe) |-> serial_out_pin && !en_seen)
    else $error("pin released while enabled or mid-bit");
  enable_drive_a: assert property ($rose(en_seen) |-> ##[0:3] serial_out_oe)
    else $error("enable did not take the pin");
  irq_gate_a: assert property (!global_irq_enable |=> !irq_tx_buffer_empty && !irq_tx_complete)
    else $error("interrupt raised while globally masked");
  ack_clear_a: assert property (tx_complete_irq_ack && irq_tx_complete |-> ##[1:3] !irq_tx_complete)
    else $error("complete interrupt not cleared by service");
endmodule : utx_assertions

bind utx_top utx_assertions i_chk (.ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .hrdata, .hresp, .global_irq_enable, .tx_complete_irq_ack, .serial_out_pin, .serial_out_oe,
  .irq_tx_buffer_empty, .irq_tx_complete);

// ===== utx_rx_model.sv
// Remote serial receiver that samples the transmit line and reports each frame.
`timescale 1ns/10ps
module utx_rx_model (
  input  wire logic        ref_clk,
  input  wire logic        line,
  input  wire logic        oe,
  input  wire logic        sync,
  input  wire logic [7:0]  bit_clks,
  input  wire logic [3:0]  nbits,
  output logic             xck,
  output logic      [12:0] bits,
  output logic             valid
);
  int   span;
  logic clocked;
  initial valid = 1'b0;
  initial xck = 1'b0;
  // Sampling mid-bit tolerates a cycle of skew on either side of each bit.
  // In synchronous mode the model clocks the transmitter, one pulse per bit and one more that
  // ends the last stop bit; the clock stays low between frames, so frames must not follow back to back.
  always begin
    @(negedge line);
    if (oe === 1'b1) begin
      repeat (bit_clks / 2) @(posedge ref_clk);
      if (line === 1'b0) begin
        bits = 13'h0;
        clocked = sync;
        span = nbits;
        for (int i = 0; i < span + int'(clocked); i++) begin
          xck <= clocked;
          repeat (bit_clks / 2) @(posedge ref_clk);
          xck <= 1'b0;
          repeat (bit_clks / 2) @(posedge ref_clk);
          if (i < span) bits[i] = line;
        end
        valid = 1'b1;
        @(posedge ref_clk);
        valid = 1'b0;
      end
    end
  end
endmodule : utx_rx_model

// ===== uart_transmitter_parity_tb.sv
// Testbench for the serial transmitter: bus tasks, frame scoreboard and scenarios.
`timescale 1ns/10ps
module uart_transmitter_parity_tb;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hready;
  logic [31:0] hrdata;
  logic        hresp;
  logic        sync_clock_pin;
  logic        tx_sync = 1'b0;
  logic        global_irq_enable = 1'b1;
  logic        tx_complete_irq_ack = 1'b0;
  logic        serial_out_pin, serial_out_oe, irq_tx_buffer_empty, irq_tx_complete;
  logic [7:0]  bit_clks = 8'h10;
  logic [3:0]  nbits = 4'h0;
  logic [12:0] rx_bits;
  logic        rx_valid;
  logic [12:0] exp_q[$];
  logic [31:0] rd;
  logic [1:0]  cur_par;
  logic        cur_s2;
  int          cur_nd, err_count = 0, total_checks = 0, seed = 26, cycles = 0;
  int          nds[5] = '{8, 9, 7, 5, 6};
  logic [1:0]  pars[5] = '{2'h2, 2'h2, 2'h3, 2'h0, 2'h3};
  logic        s2s[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  logic        dss[5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  logic [7:0]  ras[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [7:0]  res[6] = '{8'h20, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00};

  always #5 ref_clk = ~ref_clk;

  utx_top i_dut (.ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout(hready),
    .hrdata, .hresp, .sync_clock_pin, .global_irq_enable, .tx_complete_irq_ack, .serial_out_pin, .serial_out_oe,
    .irq_tx_buffer_empty, .irq_tx_complete);
  utx_rx_model i_rx (.ref_clk, .line(serial_out_pin), .oe(serial_out_oe), .sync(tx_sync), .bit_clks, .nbits,
    .xck(sync_clock_pin), .bits(rx_bits), .valid(rx_valid));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= utx_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wait_txc;
    int n;
    n = 0;
    do begin
      bus(utx_pkg::ADDR_STATUS_A, 1'b0, 32'h0);
      n++;
    end while (rd[6] !== 1'b1 && n < 600);
    chk(rd[6], 1'b1);
  endtask : wait_txc

  task automatic put(input logic [8:0] d);
    logic [12:0] f;
    int k;
    f = 13'h0;
    for (k = 0; k < cur_nd; k++) f[k] = d[k];
    if (cur_par[1]) begin
      f[k] = ^f[8:0] ^ cur_par[0];
      k++;
    end
    f[k] = 1'b1;
    f[k + 1] = cur_s2;
    exp_q.push_back(f);
    bus(utx_pkg::ADDR_DATA, 1'b1, {24'h0, d[7:0]});
  endtask : put

  task automatic frame(input int nd, input logic [1:0] par, input logic s2, input logic [11:0] div,
                       input logic ds, input int cnt, input logic [7:0] cbx, input logic [1:0] syp);
    logic [2:0] sz;
    logic [8:0] d;
    sz = (nd == 9) ? 3'h7 : 3'(nd - 5);
    cur_nd = nd;
    cur_par = par;
    cur_s2 = s2;
    tx_sync = syp[1];
    bit_clks = 8'((ds ? 8 : 16) * (div + 1));
    nbits = 4'(nd + par[1] + 1 + s2);
    bus(utx_pkg::ADDR_CONTROL_C, 1'b1, {25'h0, syp[1], par, s2, sz[1:0], syp[0]});
    bus(utx_pkg::ADDR_BAUD, 1'b1, {20'h0, div});
    bus(utx_pkg::ADDR_STATUS_A, 1'b1, {30'h0, ds, 1'b0});
    d = 9'($random(seed));
    bus(utx_pkg::ADDR_CONTROL_B, 1'b1, {24'h0, cbx | {4'h0, 1'b1, sz[2], 1'b0, d[8]}});
    for (int j = 0; j < cnt; j++) put({d[8], 8'($random(seed))});
    if (cnt > 1) begin
      bus(utx_pkg::ADDR_STATUS_A, 1'b0, 32'h0);
      chk(rd[6:5], 2'h0);
    end
    wait_txc();
    if (cbx != 8'h0) begin
      repeat (3) @(posedge ref_clk);
      chk({irq_tx_buffer_empty, irq_tx_complete}, 2'h3);
      global_irq_enable <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk({irq_tx_buffer_empty, irq_tx_complete}, 2'h0);
      global_irq_enable <= 1'b1;
      repeat (2) @(posedge ref_clk);
      tx_complete_irq_ack <= 1'b1;
      @(posedge ref_clk);
      tx_complete_irq_ack <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk({irq_tx_buffer_empty, irq_tx_complete}, 2'h2);
    end
    bus(utx_pkg::ADDR_STATUS_A, 1'b1, {25'h0, 1'b1, 4'h0, ds, 1'b0});
    bus(utx_pkg::ADDR_STATUS_A, 1'b0, 32'h0);
    chk(rd, {26'h0, 4'h8, ds, 1'b0});
  endtask : frame

  always @(posedge rx_valid) begin
    if (exp_q.size() > 0) chk(rx_bits, exp_q.pop_front());
    else chk(32'h1, 32'h0);
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      stop_test();
    end
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    chk({serial_out_oe, serial_out_pin}, 2'h1);
    foreach (ras[i]) begin
      bus(ras[i], 1'b0, 32'h0);
      chk(rd, {24'h0, res[i]});
    end
    for (int i = 0; i < 5; i++) frame(nds[i], pars[i], s2s[i], 12'(i == 2), dss[i], (i == 2) ? 2 : 1,
                                      (i == 4) ? 8'h60 : 8'h00, 2'h0);
    frame(8, 2'h3, 1'b0, 12'h0, 1'b0, 1, 8'h00, 2'h2);
    frame(5, 2'h2, 1'b1, 12'h0, 1'b0, 1, 8'h00, 2'h3);
    put(9'($random(seed)));
    bus(utx_pkg::ADDR_CONTROL_B, 1'b1, 32'h0);
    chk(serial_out_oe, 1'b1);
    wait_txc();
    bus(utx_pkg::ADDR_STATUS_A, 1'b1, 32'h40);
    repeat (3) @(posedge ref_clk);
    chk({serial_out_oe, serial_out_pin}, 2'h1);
    put(9'($random(seed)));
    repeat (40) @(posedge ref_clk);
    chk(serial_out_oe, 1'b0);
    bus(utx_pkg::ADDR_CONTROL_B, 1'b1, 32'h8);
    wait_txc();
    repeat (20) @(posedge ref_clk);
    chk(exp_q.size(), 0);
    stop_test();
  end
endmodule : uart_transmitter_parity_tb
